// [core/adcs_pkg.sv]
// constants, field positions and carrier types of the scan result and flag logic
// assumes one 200 MHz system clock and a classic wishbone master with 32-bit data
// How it works
// - threshold register: bits 15:0 lower limit, bits 31:16 upper limit
// - condition code 0 below, 1 inside, 2 at/above high, 3 outside range
// - scan results land in working registers, copied to results at scan end
// - sixteen regular channels double buffered, injection result single buffered
// - injection config holds input, differential, resolution and sample time choice
// - injection done stores result, sets its done flag, clears start bit
// - injection result carries mirrors of done, range, saturation and collision flags
// - injection has maskable done, range, saturation, collision flags, no overrun
// - interrupt output high while any pending flag has its mask bit high
// - firmware clears a flag by writing one to it after reading data
// - masked status register reads request flags AND mask bits
// - writing one to the force register sets the matching request flag
// - scan done flag rises when the regular result marked last completes a scan
// - with output enable bit 31 set, scan done pulses fabric for two cycles
// - scan completing with scan done still set raises overrun, results overwritten
// - trigger during a scan is deferred and flags collision unless level mode
// - separate collision flags for fabric trigger and injection channel
// - level fabric trigger never sets the fabric collision flag
// - start bit 31 requests injection; follow bit 30 runs it after a scan
// - when injection follows a scan, scan done rises as injection starts
// - range check on final channel result right away, same format as thresholds
// - saturation checks each raw sample for min or max code of its resolution
package adcs_pkg;
  localparam logic [7:0] ADR_THRES = 8'h00;
  localparam logic [7:0] ADR_INJ_CFG = 8'h04;
  localparam logic [7:0] ADR_SAMPLE_CTRL = 8'h08;
  localparam logic [7:0] ADR_IRQ_REQ = 8'h0C;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADR_IRQ_MASKED = 8'h14;
  localparam logic [7:0] ADR_IRQ_FORCE = 8'h18;
  localparam logic [7:0] ADR_CH_FLAG = 8'h1C;
  localparam logic [7:0] ADR_CH_MASK = 8'h20;
  localparam logic [7:0] ADR_INJECTED_RESULT = 8'h24;
  localparam logic [7:0] ADR_STATUS = 8'h28;
  localparam logic [1:0] ADR_RESULT_PAGE = 2'h1;
  localparam int NUM_CH = 16;
  localparam int NUM_IRQ = 7;
  localparam logic [4:0] INJ_CHAN = 5'h10;
  localparam int THR_LO_LSB = 0;
  localparam int THR_HI_LSB = 16;
  localparam int INJ_START_BIT = 31;
  localparam int INJ_FOLLOW_BIT = 30;
  localparam int SCTL_FAB_OUT_BIT = 31;
  localparam int SCTL_CONT_BIT = 0;
  localparam int SCTL_LEVEL_BIT = 1;
  localparam int SCTL_COND_LSB = 2;
  localparam int IRQ_SCAN_DONE = 0;
  localparam int IRQ_OVERRUN = 1;
  localparam int IRQ_FAB_COLL = 2;
  localparam int IRQ_INJ_COLL = 3;
  localparam int IRQ_INJ_DONE = 4;
  localparam int IRQ_INJ_RANGE = 5;
  localparam int IRQ_INJ_SAT = 6;
  localparam int INJR_COLL_BIT = 28;
  localparam int INJR_SAT_BIT = 29;
  localparam int INJR_RANGE_BIT = 30;
  localparam int INJR_VALID_BIT = 31;
  localparam logic [31:0] RST_THRES = 32'h0000_0000;
  localparam logic [31:0] RST_INJ_CFG = 32'h4000_0000;
  localparam logic [31:0] RST_SAMPLE_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_CH_MASK = 32'h0000_0000;
  localparam logic [NUM_IRQ-1:0] RST_IRQ_MASK = 7'h00;
  localparam logic [1:0] COND_BELOW = 2'h0;
  localparam logic [1:0] COND_INSIDE = 2'h1;
  localparam logic [1:0] COND_ABOVE = 2'h2;
  localparam logic [1:0] RES_12 = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_8 = 2'h2;
  localparam logic [1:0] SCAN_DONE_OUT_CYCLES = 2'h2;

  typedef struct packed {
    logic raw_valid;
    logic res_valid;
    logic [4:0] chan;
    logic last;
    logic [1:0] res_sel;
    logic [11:0] raw;
    logic [15:0] result;
  } adcs_sample_t;

  typedef struct packed {
    logic [3:0] input_sel;
    logic diff;
    logic alt_res;
    logic [1:0] sample_time;
  } adcs_inj_cfg_t;
endpackage

// [core/adcs_scan_irq.sv]
// scan sequencing, double buffered results, range and saturation checks and flags
// assumes the converter core answers scan_start_o and inj_conv_o with samples on conv_i
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module adcs_scan_irq
  import adcs_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire adcs_sample_t conv_i,
  input wire logic fabric_trig_i,
  output logic scan_start_o,
  output logic inj_conv_o,
  output logic scan_done_fabric_o,
  output logic irq_o,
  output logic busy_o,
  output adcs_inj_cfg_t inj_cfg_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_INJ} adcs_state_t;

  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // unsigned compare; thresholds must be in the same format as the results
  function automatic logic range_hit(input logic [1:0] cond, input logic [15:0] v,
                                     input logic [31:0] thr);
    logic lo;
    logic hi;
    lo = v < thr[THR_LO_LSB +: 16];
    hi = v >= thr[THR_HI_LSB +: 16];
    case (cond)
      COND_BELOW: range_hit = lo;
      COND_INSIDE: range_hit = !lo && !hi;
      COND_ABOVE: range_hit = hi;
      default: range_hit = lo || hi;
    endcase
  endfunction

  function automatic logic sat_hit(input logic [1:0] res, input logic [11:0] raw);
    case (res)
      RES_10: sat_hit = (raw[9:0] == 10'h000) || (raw[9:0] == 10'h3FF);
      RES_8: sat_hit = (raw[7:0] == 8'h00) || (raw[7:0] == 8'hFF);
      default: sat_hit = (raw == 12'h000) || (raw == 12'hFFF);
    endcase
  endfunction

  adcs_state_t state_q;
  logic [31:0] thres_q;
  logic [31:0] inj_cfg_q;
  logic [31:0] sctl_q;
  logic [NUM_IRQ-1:0] irq_req_q;
  logic [NUM_IRQ-1:0] irq_mask_q;
  logic [31:0] ch_flag_q;
  logic [31:0] ch_mask_q;
  logic [15:0] work_q [NUM_CH];
  logic [15:0] result_q [NUM_CH];
  logic [15:0] inj_res_q;
  logic fab_prev_q;
  logic trig_pend_q;
  logic [1:0] fab_out_cnt_q;
  logic [31:0] rdata;
  logic req;
  logic wr;
  logic [31:0] wm;
  logic [31:0] wd;
  logic busy;
  logic level_mode;
  logic fab_edge;
  logic fab_coll;
  logic inj_coll;
  logic res_reg;
  logic last_reg;
  logic inj_done;
  logic inj_raw;
  logic inj_arm;
  logic start_scan;
  logic start_inj_now;
  logic [NUM_IRQ-1:0] irq_set;
  logic [31:0] ch_set;

  assign req = wb_cyc_i && wb_stb_i;
  // writes take effect on the edge after the one that raises ack, as the master samples it
  assign wr = req && wb_we_i && wb_ack_o;
  assign wm = lane_mask(wb_sel_i);
  assign wd = wb_dat_i & wm;
  assign busy = state_q != ST_IDLE;
  assign level_mode = sctl_q[SCTL_LEVEL_BIT];
  assign fab_edge = fabric_trig_i && !fab_prev_q;
  assign fab_coll = !level_mode && fab_edge && busy;
  // a start request without follow mode collides with a running scan
  assign inj_coll = wr && (wb_adr_i == ADR_INJ_CFG) && wd[INJ_START_BIT]
                    && !(wb_dat_i[INJ_FOLLOW_BIT] && wm[INJ_FOLLOW_BIT])
                    && !inj_cfg_q[INJ_START_BIT] && busy;
  assign res_reg = conv_i.res_valid && !conv_i.chan[4] && state_q == ST_SCAN;
  assign last_reg = res_reg && conv_i.last;
  assign inj_done = conv_i.res_valid && conv_i.chan == INJ_CHAN && state_q == ST_INJ;
  assign inj_raw = conv_i.raw_valid && conv_i.chan == INJ_CHAN;
  assign inj_arm = inj_cfg_q[INJ_START_BIT];
  assign start_inj_now = state_q == ST_IDLE && inj_arm && !inj_cfg_q[INJ_FOLLOW_BIT];
  assign start_scan = state_q == ST_IDLE && !start_inj_now
                      && (trig_pend_q || (level_mode && fabric_trig_i)
                          || sctl_q[SCTL_CONT_BIT]);

  always_comb
  begin
    irq_set = '0;
    irq_set[IRQ_SCAN_DONE] = last_reg;
    irq_set[IRQ_OVERRUN] = last_reg && irq_req_q[IRQ_SCAN_DONE];
    irq_set[IRQ_FAB_COLL] = fab_coll;
    irq_set[IRQ_INJ_COLL] = inj_coll;
    irq_set[IRQ_INJ_DONE] = inj_done;
    irq_set[IRQ_INJ_RANGE] = inj_done
                             && range_hit(sctl_q[SCTL_COND_LSB +: 2], conv_i.result, thres_q);
    irq_set[IRQ_INJ_SAT] = inj_raw && sat_hit(conv_i.res_sel, conv_i.raw);
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++)
    begin : g_ch
      localparam logic [3:0] CH_IDX = 4'(gi);
      // range is judged per channel result, not held back until scan end
      assign ch_set[gi] = res_reg && conv_i.chan[3:0] == CH_IDX
                          && range_hit(sctl_q[SCTL_COND_LSB +: 2], conv_i.result,
                                       thres_q);
      assign ch_set[NUM_CH + gi] = conv_i.raw_valid && conv_i.chan == {1'b0, CH_IDX}
                                   && sat_hit(conv_i.res_sel, conv_i.raw);

      always_ff @(posedge clock_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          work_q[gi] <= 16'h0000;
          result_q[gi] <= 16'h0000;
        end
        else
        begin
          if (res_reg && conv_i.chan[3:0] == CH_IDX)
            work_q[gi] <= conv_i.result;
          // the last channel's value bypasses the working copy on the copy edge
          if (last_reg)
            result_q[gi] <= (conv_i.chan[3:0] == CH_IDX) ? conv_i.result
                                                          : work_q[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_q <= ST_IDLE;
      scan_start_o <= 1'b0;
      inj_conv_o <= 1'b0;
    end
    else
    begin
      scan_start_o <= 1'b0;
      inj_conv_o <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (start_inj_now)
          begin
            state_q <= ST_INJ;
            inj_conv_o <= 1'b1;
          end
          else if (start_scan)
          begin
            state_q <= ST_SCAN;
            scan_start_o <= 1'b1;
          end
        end
        ST_SCAN:
        begin
          if (last_reg && inj_arm)
          begin
            state_q <= ST_INJ;
            inj_conv_o <= 1'b1;
          end
          else if (last_reg)
            state_q <= ST_IDLE;
        end
        ST_INJ:
        begin
          if (inj_done)
            state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // pulse triggers are remembered so a busy sequencer runs them afterwards
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      fab_prev_q <= 1'b0;
      trig_pend_q <= 1'b0;
    end
    else
    begin
      fab_prev_q <= fabric_trig_i;
      if (!level_mode && fab_edge)
        trig_pend_q <= 1'b1;
      else if (start_scan)
        trig_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      thres_q <= RST_THRES;
      sctl_q <= RST_SAMPLE_CTRL;
      irq_mask_q <= RST_IRQ_MASK;
      ch_mask_q <= RST_CH_MASK;
    end
    else if (wr)
    begin
      case (wb_adr_i)
        ADR_THRES: thres_q <= (thres_q & ~wm) | wd;
        ADR_SAMPLE_CTRL: sctl_q <= (sctl_q & ~wm) | wd;
        ADR_IRQ_MASK: irq_mask_q <= (irq_mask_q & ~wm[NUM_IRQ-1:0]) | wd[NUM_IRQ-1:0];
        ADR_CH_MASK: ch_mask_q <= (ch_mask_q & ~wm) | wd;
        default: thres_q <= thres_q;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      inj_cfg_q <= RST_INJ_CFG;
    else if (wr && wb_adr_i == ADR_INJ_CFG)
      inj_cfg_q <= (inj_cfg_q & ~wm) | wd;
    else if (inj_done)
      inj_cfg_q[INJ_START_BIT] <= 1'b0;
  end

  // flags: set wins over a same-cycle write-one clear
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      irq_req_q <= '0;
      ch_flag_q <= 32'h0000_0000;
    end
    else
    begin
      irq_req_q <= (irq_req_q & ~((wr && wb_adr_i == ADR_IRQ_REQ) ? wd[NUM_IRQ-1:0] : '0))
                   | ((wr && wb_adr_i == ADR_IRQ_FORCE) ? wd[NUM_IRQ-1:0] : '0)
                   | irq_set;
      ch_flag_q <= (ch_flag_q & ~((wr && wb_adr_i == ADR_CH_FLAG) ? wd : 32'h0000_0000))
                   | ch_set;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      inj_res_q <= 16'h0000;
    else if (inj_done)
      inj_res_q <= conv_i.result;
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      fab_out_cnt_q <= 2'h0;
      scan_done_fabric_o <= 1'b0;
    end
    else
    begin
      if (last_reg && sctl_q[SCTL_FAB_OUT_BIT])
      begin
        fab_out_cnt_q <= SCAN_DONE_OUT_CYCLES - 2'h1;
        scan_done_fabric_o <= 1'b1;
      end
      else if (fab_out_cnt_q != 2'h0)
        fab_out_cnt_q <= fab_out_cnt_q - 2'h1;
      else
        scan_done_fabric_o <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      irq_o <= 1'b0;
      busy_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(irq_req_q & irq_mask_q) || |(ch_flag_q & ch_mask_q);
      busy_o <= busy;
    end
  end

  assign inj_cfg_o = inj_cfg_q[7:0];

  always_comb
  begin
    rdata = 32'h0000_0000;
    if (wb_adr_i[7:6] == ADR_RESULT_PAGE)
      rdata[15:0] = result_q[wb_adr_i[5:2]];
    else
    begin
      case (wb_adr_i)
        ADR_THRES: rdata = thres_q;
        ADR_INJ_CFG: rdata = inj_cfg_q;
        ADR_SAMPLE_CTRL: rdata = sctl_q;
        ADR_IRQ_REQ, ADR_IRQ_FORCE: rdata[NUM_IRQ-1:0] = irq_req_q;
        ADR_IRQ_MASK: rdata[NUM_IRQ-1:0] = irq_mask_q;
        ADR_IRQ_MASKED: rdata[NUM_IRQ-1:0] = irq_req_q & irq_mask_q;
        ADR_CH_FLAG: rdata = ch_flag_q;
        ADR_CH_MASK: rdata = ch_mask_q;
        ADR_INJECTED_RESULT:
        begin
          rdata[15:0] = inj_res_q;
          rdata[INJR_COLL_BIT] = irq_req_q[IRQ_INJ_COLL];
          rdata[INJR_SAT_BIT] = irq_req_q[IRQ_INJ_SAT];
          rdata[INJR_RANGE_BIT] = irq_req_q[IRQ_INJ_RANGE];
          rdata[INJR_VALID_BIT] = irq_req_q[IRQ_INJ_DONE];
        end
        ADR_STATUS: rdata[2:0] = {inj_arm, trig_pend_q, busy};
        default: rdata = 32'h0000_0000;
      endcase
    end
  end

  // one wait state; unmapped addresses are acked and read as zero
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req && !wb_ack_o;
      if (req && !wb_ack_o && !wb_we_i)
        wb_dat_o <= rdata;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  sequence s_fab_two;
    scan_done_fabric_o [*2] ##1 !scan_done_fabric_o;
  endsequence

  a_thres_write: assert property ((wr && wb_adr_i == ADR_THRES && wb_sel_i == 4'hF)
    |=> thres_q == $past(wb_dat_i)) else $error("threshold write not stored");
  a_range_below: assert property ((res_reg && conv_i.chan[3:0] == 4'h0
    && sctl_q[SCTL_COND_LSB +: 2] == COND_BELOW && conv_i.result < thres_q[15:0])
    |=> ch_flag_q[0]) else $error("below range flag missing");
  a_result_hold: assert property (!last_reg |=> $stable(result_q[0]))
    else $error("result changed outside scan end");
  a_inj_done: assert property (inj_done |=> irq_req_q[IRQ_INJ_DONE]
    && !inj_cfg_q[INJ_START_BIT] && inj_res_q == $past(conv_i.result))
    else $error("injection completion wrong");
  a_irq_out: assert property (|(irq_req_q & irq_mask_q) |=> irq_o)
    else $error("interrupt output not raised");
  a_flag_clear: assert property ((wr && wb_adr_i == ADR_IRQ_REQ && wd[0]
    && !last_reg) |=> !irq_req_q[IRQ_SCAN_DONE]) else $error("write one did not clear");
  a_force_set: assert property ((wr && wb_adr_i == ADR_IRQ_FORCE && wd[1])
    |=> irq_req_q[IRQ_OVERRUN]) else $error("force did not set flag");
  a_fab_pulse: assert property ((last_reg && sctl_q[SCTL_FAB_OUT_BIT]) |=> s_fab_two)
    else $error("fabric scan done not two cycles");
  a_overrun_set: assert property ((last_reg && irq_req_q[IRQ_SCAN_DONE])
    |=> irq_req_q[IRQ_OVERRUN]) else $error("overrun not raised");
  a_level_coll: assert property ((level_mode && !(wr && wb_adr_i == ADR_IRQ_FORCE)
    && !irq_req_q[IRQ_FAB_COLL]) |=> !irq_req_q[IRQ_FAB_COLL])
    else $error("collision set in level mode");
  a_tailgate: assert property ((last_reg && inj_arm) |=> inj_conv_o
    && irq_req_q[IRQ_SCAN_DONE] && state_q == ST_INJ) else $error("tailgate start wrong");
endmodule

// [test/adcs_conv_model.sv]
// behavioural converter core: answers scan starts with three channels, injection with one
// assumes start pulses last one cycle and are sampled on the rising clock edge
`timescale 1ns/1ps
module adcs_conv_model
  import adcs_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic scan_start_i,
  input wire logic inj_conv_i,
  input wire logic [15:0] base_i,
  input wire logic [1:0] res_i,
  output adcs_sample_t conv_o
);
  // slow enough answers that a scan stays open across a register read
  localparam int GAP = 6;

  task automatic send(input logic [4:0] ch, input logic lst, input logic [15:0] v);
    repeat (GAP) @(posedge clock_i);
    conv_o.raw_valid <= 1'b1;
    conv_o.res_valid <= 1'b1;
    conv_o.chan <= ch;
    conv_o.last <= lst;
    conv_o.res_sel <= res_i;
    conv_o.raw <= v[11:0];
    conv_o.result <= v;
    @(posedge clock_i);
    conv_o.raw_valid <= 1'b0;
    conv_o.res_valid <= 1'b0;
    conv_o.last <= 1'b0;
    // data lines show garbage between strobes, never the last value
    conv_o.raw <= ~v[11:0];
    conv_o.result <= ~v;
  endtask

  initial
  begin
    conv_o = '0;
    forever
    begin
      @(posedge clock_i);
      if (nrst_i === 1'b1 && scan_start_i === 1'b1)
      begin
        for (int i = 0; i < 3; i++)
        begin
          send(5'(i), i == 2, base_i + 16'(i << 8));
        end
      end
      else if (nrst_i === 1'b1 && inj_conv_i === 1'b1)
      begin
        send(INJ_CHAN, 1'b0, base_i + 16'h0800);
      end
    end
  end
endmodule

// [test/tb_top.sv]
// self-checking bench for the scan result and flag logic
// assumes the converter model answers every start; wishbone driven on rising edges
`timescale 1ns/1ps
module tb_top
  import adcs_pkg::*;
;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, fab_trig = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0, rd_q;
  logic [15:0] base = 16'h0000;
  logic [1:0] res_sel = RES_12;
  logic wb_ack, scan_start, inj_conv, fab_out, irq, busy;
  logic [31:0] wb_rdat;
  adcs_sample_t conv;
  adcs_inj_cfg_t inj_cfg;
  int fail_count = 0, num_checks = 0, starts = 0, injs = 0, fab_run = 0, fab_len = 0;

  always #2.5 clock_i = ~clock_i;

  adcs_scan_irq adcs_scan_irq_i (.clock_i(clock_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_ack_o(wb_ack), .wb_dat_o(wb_rdat), .conv_i(conv),
    .fabric_trig_i(fab_trig), .scan_start_o(scan_start), .inj_conv_o(inj_conv),
    .scan_done_fabric_o(fab_out), .irq_o(irq), .busy_o(busy), .inj_cfg_o(inj_cfg));
  adcs_conv_model adcs_conv_model_i (.clock_i(clock_i), .nrst_i(nrst_i),
    .scan_start_i(scan_start), .inj_conv_i(inj_conv), .base_i(base), .res_i(res_sel),
    .conv_o(conv));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  always @(posedge clock_i)
  begin
    if (scan_start === 1'b1)
      starts++;
    if (inj_conv === 1'b1)
    begin
      injs++;
      chk("fabric scan done at injection start", 32'h1, {31'h0, fab_out});
    end
    if (fab_out === 1'b1)
      fab_run++;
    else if (fab_run != 0)
    begin
      fab_len = fab_run;
      fab_run = 0;
    end
  end

  task automatic wb(input logic we_v, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we_v;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= 4'hF;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 50);
    rd_q = wb_rdat;
    if (n >= 50)
      chk("wishbone ack", 32'h1, 32'h0);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
    input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, e & m, rd_q & m);
  endtask

  task automatic settle;
    repeat (3) @(posedge clock_i);
  endtask

  task automatic trig;
    @(posedge clock_i);
    fab_trig <= 1'b1;
    repeat (2) @(posedge clock_i);
    fab_trig <= 1'b0;
  endtask

  task automatic wait_idle;
    int n;
    int quiet;
    n = 0;
    quiet = 0;
    repeat (4) @(posedge clock_i);
    // busy drops for a single cycle between a scan and a deferred one
    while (quiet < 3 && n < 500)
    begin
      @(posedge clock_i);
      n++;
      quiet = (busy === 1'b0) ? quiet + 1 : 0;
    end
    if (n >= 500)
      chk("sequencer idle", 32'h1, 32'h0);
    // covers a following injection conversion as well
    repeat (12) @(posedge clock_i);
  endtask

  task automatic do_scan(input logic [15:0] b);
    base = b;
    trig;
    wait_idle;
  endtask

  task automatic chk_res(input logic [15:0] b);
    for (int i = 0; i < 3; i++)
      rdm(8'h40 + 8'(4 * i), 32'hFFFF, {16'h0, b + 16'(i << 8)}, "channel result");
  endtask

  task automatic t_regs;
    rdm(ADR_THRES, '1, RST_THRES, "threshold reset");
    rdm(ADR_INJ_CFG, '1, RST_INJ_CFG, "injection config reset");
    rdm(ADR_IRQ_MASK, '1, 32'h0, "mask reset");
    rdm(8'h3C, '1, 32'h0, "unmapped read");
    wr(ADR_THRES, 32'h0200_0100);
    rdm(ADR_THRES, '1, 32'h0200_0100, "threshold");
  endtask

  task automatic t_irq;
    wr(ADR_IRQ_MASK, 32'h1);
    wr(ADR_IRQ_FORCE, 32'h3);
    rdm(ADR_IRQ_REQ, 32'h7F, 32'h3, "request after force");
    rdm(ADR_IRQ_MASKED, '1, 32'h1, "masked status");
    settle;
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(ADR_IRQ_MASK, 32'h0);
    settle;
    chk("irq masked off", 32'h0, {31'h0, irq});
    wr(ADR_IRQ_REQ, 32'h1);
    rdm(ADR_IRQ_REQ, 32'h7F, 32'h2, "request after clear");
    wr(ADR_IRQ_REQ, 32'h7F);
  endtask

  task automatic t_scan;
    wr(ADR_SAMPLE_CTRL, 32'h8000_0000);
    do_scan(16'h00FF);
    rdm(ADR_IRQ_REQ, 32'h3, 32'h1, "scan done without overrun");
    chk("fabric scan done length", 32'h2, 32'(fab_len));
    chk_res(16'h00FF);
    base = 16'h0411;
    trig;
    repeat (10) @(posedge clock_i);
    rdm(8'h40, 32'hFFFF, 32'h00FF, "result held during scan");
    wait_idle;
    rdm(ADR_IRQ_REQ, 32'h3, 32'h3, "overrun");
    chk_res(16'h0411);
  endtask

  task automatic t_range;
    logic [2:0] exp_f [4];
    exp_f = '{3'b001, 3'b010, 3'b100, 3'b101};
    for (int c = 0; c < 4; c++)
    begin
      wr(ADR_SAMPLE_CTRL, 32'h8000_0000 | (32'(c) << 2));
      wr(ADR_CH_FLAG, 32'hFFFF_FFFF);
      do_scan(16'h00FF);
      rdm(ADR_CH_FLAG, 32'h7, {29'h0, exp_f[c]}, "range flags");
    end
    wr(ADR_CH_FLAG, 32'hFFFF_FFFF);
    do_scan(16'h0FFF);
    rdm(ADR_CH_FLAG, 32'h0007_0000, 32'h0001_0000, "saturation flags");
    wr(ADR_CH_MASK, 32'h0001_0000);
    settle;
    chk("irq from channel flag", 32'h1, {31'h0, irq});
    wr(ADR_CH_MASK, 32'h0);
    settle;
    chk("channel flag masked off", 32'h0, {31'h0, irq});
    res_sel = RES_10;
    wr(ADR_CH_FLAG, 32'hFFFF_FFFF);
    do_scan(16'h03FF);
    rdm(ADR_CH_FLAG, 32'h0007_0000, 32'h0001_0000, "10-bit saturation");
    res_sel = RES_8;
    wr(ADR_CH_FLAG, 32'hFFFF_FFFF);
    do_scan(16'h0100);
    rdm(ADR_CH_FLAG, 32'h0007_0000, 32'h0007_0000, "8-bit saturation");
    res_sel = RES_12;
  endtask

  task automatic t_coll;
    int s0;
    wr(ADR_SAMPLE_CTRL, 32'h8000_0000);
    wr(ADR_IRQ_REQ, 32'h7F);
    s0 = starts;
    trig;
    repeat (6) @(posedge clock_i);
    trig;
    wait_idle;
    chk("deferred scan count", 32'h2, 32'(starts - s0));
    rdm(ADR_IRQ_REQ, 32'h0C, 32'h04, "fabric collision only");
    wr(ADR_SAMPLE_CTRL, 32'h8000_0002);
    wr(ADR_IRQ_REQ, 32'h7F);
    s0 = starts;
    @(posedge clock_i);
    fab_trig <= 1'b1;
    repeat (40) @(posedge clock_i);
    fab_trig <= 1'b0;
    wait_idle;
    chk("level scans repeat", 32'h1, {31'h0, starts - s0 >= 2});
    rdm(ADR_IRQ_REQ, 32'h4, 32'h0, "no level collision");
    s0 = starts;
    wr(ADR_SAMPLE_CTRL, 32'h8000_0001);
    repeat (60) @(posedge clock_i);
    wr(ADR_SAMPLE_CTRL, 32'h8000_0000);
    wait_idle;
    chk("continuous scans repeat", 32'h1, {31'h0, starts - s0 >= 2});
    rdm(ADR_IRQ_REQ, 32'h4, 32'h0, "no continuous collision");
  endtask

  task automatic t_inj;
    int s0;
    wr(ADR_IRQ_REQ, 32'h7F);
    s0 = injs;
    wr(ADR_INJ_CFG, 32'hC000_00A5);
    settle;
    chk("injection config out", 32'hA5, {24'h0, inj_cfg});
    repeat (20) @(posedge clock_i);
    chk("no injection while idle", 32'h0, 32'(injs - s0));
    do_scan(16'h0300);
    chk("injection after scan", 32'h1, 32'(injs - s0));
    rdm(ADR_INJECTED_RESULT, 32'h8000_FFFF, 32'h8000_0B00, "injection result");
    rdm(ADR_IRQ_REQ, 32'h13, 32'h11, "injection done, no overrun");
    rdm(ADR_INJ_CFG, 32'h8000_00FF, 32'h0000_00A5, "start bit cleared");
    wr(ADR_IRQ_REQ, 32'h10);
    rdm(ADR_INJECTED_RESULT, 32'h8000_0000, 32'h0, "valid mirror cleared");
    wr(ADR_IRQ_REQ, 32'h7F);
    s0 = injs;
    base = 16'h0120;
    trig;
    repeat (4) @(posedge clock_i);
    wr(ADR_INJ_CFG, 32'h8000_00A5);
    wait_idle;
    chk("injection deferred after scan", 32'h1, 32'(injs - s0));
    rdm(ADR_IRQ_REQ, 32'h1C, 32'h18, "injection collision");
    rdm(ADR_INJECTED_RESULT, 32'h9000_FFFF, 32'h9000_0920, "collision mirror");
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #300000;
    fail_count++;
    summarize;
  end

  initial
  begin
    repeat (20) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    t_regs;
    t_irq;
    t_scan;
    t_range;
    t_coll;
    t_inj;
    summarize;
  end
endmodule
